// File: common/rpm_consts.vh
// Purpose: constants for the receive-port monitor and status register bank
// Assumes: 8-bit register addresses and data
// Notes: times are in ns; cycle counts derive from the core clock period
`ifndef RPM_CONSTS_VH
`define RPM_CONSTS_VH
`define RPM_ADDR_PORT_SEL 8'h4C
`define RPM_ADDR_LEN_HIGH 8'h75
`define RPM_ADDR_LEN_LOW 8'h76
`define RPM_ADDR_FREQ_CTL 8'h77
`define RPM_ADDR_MBOX_A 8'h78
`define RPM_ADDR_MBOX_B 8'h79
`define RPM_ADDR_PKT_STS 8'h7A
`define RPM_FREQ_CTL_RST 8'hC5
`define RPM_MBOX_A_RST 8'h00
`define RPM_MBOX_B_RST 8'h01
`define RPM_HYST_MSB 7
`define RPM_HYST_LSB 6
`define RPM_STAB_MSB 5
`define RPM_STAB_LSB 4
`define RPM_LOTH_MSB 3
`define RPM_LOTH_LSB 0
`define RPM_STS_LEN 3
`define RPM_STS_CRC 2
`define RPM_STS_ECC2 1
`define RPM_STS_ECC1 0
`define RPM_CLK_PERIOD_NS 4
`define RPM_STAB_T0_NS 40000
`define RPM_STAB_T1_NS 80000
`define RPM_STAB_T2_NS 320000
`define RPM_STAB_T3_NS 1280000
`define RPM_STAB_C0 (`RPM_STAB_T0_NS / `RPM_CLK_PERIOD_NS)
`define RPM_STAB_C1 (`RPM_STAB_T1_NS / `RPM_CLK_PERIOD_NS)
`define RPM_STAB_C2 (`RPM_STAB_T2_NS / `RPM_CLK_PERIOD_NS)
`define RPM_STAB_C3 (`RPM_STAB_T3_NS / `RPM_CLK_PERIOD_NS)
`endif

// File: logic/rpm_sync2.v
// Purpose: two-flop synchroniser for a bus of levels
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module rpm_sync2 #(
   parameter W = 1
) (
   // clock and reset
   input wire core_clk,
   input wire resetn,
   // data
   input wire [W-1:0] d_in,
   output reg [W-1:0] d_out
);
   reg [W-1:0] meta_q;
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= {W{1'b0}};
         d_out <= {W{1'b0}};
      end else begin
         meta_q <= d_in;
         d_out <= meta_q;
      end
   end
endmodule // rpm_sync2

// File: logic/rpm_freq_det.v
// Purpose: per-port frequency detector with hysteresis, stability and low threshold
// Assumes: freq_mhz is a measurement in MHz, valid with freq_vld pulse, same clock
// Notes: stability counter restarts on any out-of-band sample
`timescale 1ns/1ps
`include "rpm_consts.vh"
module rpm_freq_det #(
   parameter FW = 8,
   parameter [31:0] STAB_C0 = `RPM_STAB_C0,
   parameter [31:0] STAB_C1 = `RPM_STAB_C1,
   parameter [31:0] STAB_C2 = `RPM_STAB_C2,
   parameter [31:0] STAB_C3 = `RPM_STAB_C3
) (
   // clock and reset
   input wire core_clk,
   input wire resetn,
   // settings
   input wire [1:0] hyst_mhz,
   input wire [1:0] stab_sel,
   input wire [3:0] low_thr_mhz,
   // measurement
   input wire freq_vld,
   input wire [FW-1:0] freq_mhz,
   // results
   output reg [FW-1:0] freq_q,
   output reg stable_q,
   output reg link_clock_missing_q
);
   reg [31:0] cnt_q;
   reg [31:0] limit;
   wire [FW-1:0] diff = (freq_mhz > freq_q) ? (freq_mhz - freq_q) : (freq_q - freq_mhz);
   wire out_band = diff > {{(FW-2){1'b0}}, hyst_mhz};
   always @* begin
      case (stab_sel)
         2'h0: limit = STAB_C0;
         2'h1: limit = STAB_C1;
         2'h2: limit = STAB_C2;
         default: limit = STAB_C3;
      endcase
   end
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         freq_q <= {FW{1'b0}};
         cnt_q <= 32'h0;
         stable_q <= 1'b0;
         link_clock_missing_q <= 1'b1;
      end else begin
         if (freq_vld && out_band) begin
            freq_q <= freq_mhz;
            cnt_q <= 32'h0;
            stable_q <= 1'b0;
         end else if (cnt_q >= limit) begin
            stable_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 32'h1;
         end
         if (freq_vld)
            link_clock_missing_q <= freq_mhz < {{(FW-4){1'b0}}, low_thr_mhz};
      end
   end
endmodule // rpm_freq_det

// File: logic/rpm_port_bank.v
// Purpose: receive-port monitor and status registers, one copy per port
// Assumes: host register port is a byte-wide read/write strobe interface on core_clk
// Notes: video and packet event inputs arrive from another domain and are synchronised
`timescale 1ns/1ps
`include "rpm_consts.vh"
module rpm_port_bank #(
   parameter NP = 4,
   parameter FW = 8,
   parameter [31:0] STAB_C0 = `RPM_STAB_C0,
   parameter [31:0] STAB_C1 = `RPM_STAB_C1,
   parameter [31:0] STAB_C2 = `RPM_STAB_C2,
   parameter [31:0] STAB_C3 = `RPM_STAB_C3
) (
   // clock and reset
   input wire core_clk,
   input wire resetn,
   // host register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg reg_rvalid,
   // port-select mask, one bit per port
   input wire [NP-1:0] port_sel,
   // per-port controls from neighbouring registers
   input wire [NP-1:0] line_length_change_irq_enable,
   input wire [NP-1:0] zero_stats_when_unqualified,
   input wire [NP-1:0] pass_flag,
   // per-port video timing (other domain)
   input wire [NP-1:0] line_valid,
   input wire [NP-1:0] frame_valid,
   // per-port packet error events (other domain levels)
   input wire [NP-1:0] evt_length_err,
   input wire [NP-1:0] evt_crc_err,
   input wire [NP-1:0] evt_header_multibit_fault_flag,
   input wire [NP-1:0] evt_header_singlebit_fault_flag,
   // per-port frequency measurement
   input wire [NP-1:0] freq_vld,
   input wire [NP*FW-1:0] freq_mhz,
   // per-port status out
   output reg [NP-1:0] link_clock_missing,
   output reg [NP-1:0] freq_stable
);
   wire [NP-1:0] lv_s, fv_s, le_s, ce_s, e2_s, e1_s;
   rpm_sync2 #(.W(6*NP)) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .d_in({line_valid, frame_valid, evt_length_err, evt_crc_err, evt_header_multibit_fault_flag, evt_header_singlebit_fault_flag}),
      .d_out({lv_s, fv_s, le_s, ce_s, e2_s, e1_s})
   );
   // first selected port answers reads
   function [1:0] first_port;
      input [NP-1:0] sel;
      integer k;
      begin
         first_port = 2'h0;
         for (k = NP-1; k >= 0; k = k - 1)
            if (sel[k])
               first_port = k[1:0];
      end
   endfunction
   wire [1:0] rp = first_port(port_sel);
   wire hit_wr = reg_wr;
   wire rd_hi = reg_rd && (reg_addr == `RPM_ADDR_LEN_HIGH);
   wire rd_lo = reg_rd && (reg_addr == `RPM_ADDR_LEN_LOW);
   wire rd_sts = reg_rd && (reg_addr == `RPM_ADDR_PKT_STS);
   reg [7:0] freq_ctl_q [0:NP-1];
   reg [7:0] mbox_a_q [0:NP-1];
   reg [7:0] mbox_b_q [0:NP-1];
   reg [3:0] sts_q [0:NP-1];
   reg [15:0] len_cnt_q [0:NP-1];
   reg [15:0] last_line_q [0:NP-1];
   reg [15:0] len_q [0:NP-1];
   reg [7:0] lo_snap_q [0:NP-1];
   reg [NP-1:0] frozen_q, lv_q, fv_q, snap_vld_q;
   wire [NP-1:0] lcm_w, stab_w;
   genvar g;
   generate
      for (g = 0; g < NP; g = g + 1) begin : g_port
         wire line_end = lv_q[g] && !lv_s[g];
         wire frame_end = fv_q[g] && !fv_s[g];
         wire sel = port_sel[g];
         wire rd_me = (rp == g) && (port_sel != {NP{1'b0}});
         wire [3:0] sts_set = {le_s[g], ce_s[g], e2_s[g], e1_s[g]};
         wire [15:0] last_w = line_end ? len_cnt_q[g] : last_line_q[g];
         always @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               freq_ctl_q[g] <= `RPM_FREQ_CTL_RST;
               mbox_a_q[g] <= `RPM_MBOX_A_RST;
               mbox_b_q[g] <= `RPM_MBOX_B_RST;
               sts_q[g] <= 4'h0;
               len_cnt_q[g] <= 16'h0;
               last_line_q[g] <= 16'h0;
               len_q[g] <= 16'h0;
               lo_snap_q[g] <= 8'h0;
               snap_vld_q[g] <= 1'b0;
               frozen_q[g] <= 1'b0;
               lv_q[g] <= 1'b0;
               fv_q[g] <= 1'b0;
            end else begin
               lv_q[g] <= lv_s[g];
               fv_q[g] <= fv_s[g];
               // line length counting
               if (lv_s[g])
                  len_cnt_q[g] <= lv_q[g] ? len_cnt_q[g] + 16'h1 : 16'h1;
               if (line_end)
                  last_line_q[g] <= len_cnt_q[g];
               // publish at frame end unless frozen
               if (frame_end && !frozen_q[g]) begin
                  len_q[g] <= last_w;
                  frozen_q[g] <= line_length_change_irq_enable[g];
               end else if (rd_me && (rd_hi || rd_lo)) begin
                  frozen_q[g] <= 1'b0;
               end
               if (rd_me && rd_hi) begin
                  lo_snap_q[g] <= len_q[g][7:0];
                  snap_vld_q[g] <= 1'b1;
               end else if (rd_me && rd_lo) begin
                  snap_vld_q[g] <= 1'b0;
               end
               // host writes reach every selected port
               if (hit_wr && sel) begin
                  case (reg_addr)
                     `RPM_ADDR_FREQ_CTL: freq_ctl_q[g] <= reg_wdata;
                     `RPM_ADDR_MBOX_A: mbox_a_q[g] <= reg_wdata;
                     `RPM_ADDR_MBOX_B: mbox_b_q[g] <= reg_wdata;
                     default: ;
                  endcase
               end
               // sticky flags, set wins over clear-on-read
               if (rd_me && rd_sts)
                  sts_q[g] <= sts_set;
               else
                  sts_q[g] <= sts_q[g] | sts_set;
            end
         end
         rpm_freq_det #(
            .FW(FW),
            .STAB_C0(STAB_C0),
            .STAB_C1(STAB_C1),
            .STAB_C2(STAB_C2),
            .STAB_C3(STAB_C3)
         ) u_fdet (
            .core_clk(core_clk),
            .resetn(resetn),
            .hyst_mhz(freq_ctl_q[g][`RPM_HYST_MSB:`RPM_HYST_LSB]),
            .stab_sel(freq_ctl_q[g][`RPM_STAB_MSB:`RPM_STAB_LSB]),
            .low_thr_mhz(freq_ctl_q[g][`RPM_LOTH_MSB:`RPM_LOTH_LSB]),
            .freq_vld(freq_vld[g]),
            .freq_mhz(freq_mhz[g*FW +: FW]),
            .freq_q(),
            .stable_q(stab_w[g]),
            .link_clock_missing_q(lcm_w[g])
         );
      end
   endgenerate
   // read mux for the port that answers
   wire zero_len = zero_stats_when_unqualified[rp] && !pass_flag[rp];
   reg [7:0] rmux;
   always @* begin
      rmux = 8'h00;
      case (reg_addr)
         `RPM_ADDR_LEN_HIGH: rmux = zero_len ? 8'h00 : len_q[rp][15:8];
         `RPM_ADDR_LEN_LOW:
            rmux = zero_len ? 8'h00 : (snap_vld_q[rp] ? lo_snap_q[rp] : len_q[rp][7:0]);
         `RPM_ADDR_FREQ_CTL: rmux = freq_ctl_q[rp];
         `RPM_ADDR_MBOX_A: rmux = mbox_a_q[rp];
         `RPM_ADDR_MBOX_B: rmux = mbox_b_q[rp];
         `RPM_ADDR_PKT_STS: rmux = {4'h0, sts_q[rp]};
         default: rmux = 8'h00;
      endcase
   end
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
         link_clock_missing <= {NP{1'b1}};
         freq_stable <= {NP{1'b0}};
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= rmux;
         link_clock_missing <= lcm_w;
         freq_stable <= stab_w;
      end
   end
endmodule // rpm_port_bank

// File: bench/rpm_port_bank_chk.sv
// Purpose: concurrent checks on the port bank's register and status ports
// Assumes: port 0 is watched; reads come from the lowest selected port
// Notes: bound onto rpm_port_bank
`timescale 1ns/1ps
module rpm_port_bank_chk #(
   parameter NP = 4,
   parameter FW = 8,
   parameter [31:0] STAB_C0 = 20
) (
   // clock and reset
   input wire core_clk,
   input wire resetn,
   // host register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire reg_rvalid,
   input wire [NP-1:0] port_sel,
   // events, measurement and status
   input wire [NP-1:0] evt_length_err,
   input wire [NP-1:0] evt_crc_err,
   input wire [NP-1:0] evt_header_multibit_fault_flag,
   input wire [NP-1:0] evt_header_singlebit_fault_flag,
   input wire [NP-1:0] freq_vld,
   input wire [NP*FW-1:0] freq_mhz,
   input wire [NP-1:0] link_clock_missing,
   input wire [NP-1:0] freq_stable
);
   logic [3:0] thr_q;
   logic [7:0] quiet_q;
   logic [31:0] low_q;
   wire sts_rd0 = reg_rd && reg_addr == 8'h7A && port_sel[0];
   wire evt0 = evt_length_err[0] | evt_crc_err[0] | evt_header_multibit_fault_flag[0] | evt_header_singlebit_fault_flag[0];
   // shadow of port 0 low threshold, quiet time and low time of stable
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         thr_q <= 4'h5;
         quiet_q <= 8'h00;
         low_q <= 32'h0;
      end else begin
         if (reg_wr && reg_addr == 8'h77 && port_sel[0]) thr_q <= reg_wdata[3:0];
         quiet_q <= evt0 ? 8'h00 : (quiet_q == 8'hFF ? quiet_q : quiet_q + 8'h01);
         low_q <= freq_stable[0] ? 32'h0 : low_q + 32'h1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_len_seen;
      evt_length_err[0] ##1 !sts_rd0 [*4] ##1 sts_rd0;
   endsequence
   sequence s_clean_pair;
      sts_rd0 && quiet_q >= 8'h04 ##2 sts_rd0 && quiet_q >= 8'h06;
   endsequence
   sequence s_mbox_pair;
      reg_wr && reg_addr == 8'h78 && port_sel == 4'h2 ##2 reg_rd && reg_addr == 8'h78;
   endsequence
   a_read_answered: assert property (reg_rd |=> reg_rvalid)
      else $error("read without answer");
   a_len_flag_set: assert property (s_len_seen |=> reg_rdata[3])
      else $error("length error flag missing");
   a_flags_clear_read: assert property (s_clean_pair |=> reg_rdata[3:0] == 4'h0)
      else $error("flags not cleared by read");
   a_sts_upper_zero: assert property (sts_rd0 |=> reg_rdata[7:4] == 4'h0)
      else $error("reserved status bits set");
   a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h75 || reg_addr > 8'h7A)
      |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_mbox_write_read: assert property (s_mbox_pair |=> reg_rdata == $past(reg_wdata, 3))
      else $error("mailbox readback wrong");
   a_missing_below_thr: assert property (freq_vld[0] |-> ##2 link_clock_missing[0] ==
      ($past(freq_mhz[7:0], 2) < {4'h0, $past(thr_q, 2)}))
      else $error("missing clock status wrong");
   a_stable_min_time: assert property ($rose(freq_stable[0]) |-> low_q >= STAB_C0 - 2)
      else $error("stable too early");
endmodule // rpm_port_bank_chk
bind rpm_port_bank rpm_port_bank_chk #(.NP(NP), .FW(FW), .STAB_C0(STAB_C0)) u_rpm_port_bank_chk (
   .core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .port_sel(port_sel), .evt_length_err(evt_length_err),
   .evt_crc_err(evt_crc_err), .evt_header_multibit_fault_flag(evt_header_multibit_fault_flag), .evt_header_singlebit_fault_flag(evt_header_singlebit_fault_flag),
   .freq_vld(freq_vld), .freq_mhz(freq_mhz), .link_clock_missing(link_clock_missing),
   .freq_stable(freq_stable)
);

// File: bench/rpm_far_model.sv
// Purpose: far side: video timing, packet error events, clock measurement
// Assumes: tasks are entered on a falling edge of core_clk
// Notes: all lines but freq_mhz idle low between frames; freq_mhz holds the last measurement
`timescale 1ns/1ps
module rpm_far_model (
   // clock
   input wire core_clk,
   // far-side lines, one bit per port; freq_mhz eight bits per port
   output logic [3:0] line_valid,
   output logic [3:0] frame_valid,
   output logic [3:0] evt_length_err,
   output logic [3:0] evt_crc_err,
   output logic [3:0] evt_header_multibit_fault_flag,
   output logic [3:0] evt_header_singlebit_fault_flag,
   output logic [3:0] freq_vld,
   output logic [31:0] freq_mhz
);
   initial begin
      {line_valid, frame_valid, evt_length_err, evt_crc_err} = 16'h0000;
      {evt_header_multibit_fault_flag, evt_header_singlebit_fault_flag, freq_vld, freq_mhz} = 44'h0;
   end
   // one line of n cycles on port p
   task line(input int p, input int n);
      line_valid[p] = 1'b1;
      repeat (n) @(negedge core_clk);
      line_valid[p] = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask
   // frame of two lines; the last one is the length to report
   task frame(input int p, input int n1, input int n2);
      frame_valid[p] = 1'b1;
      repeat (3) @(negedge core_clk);
      line(p, n1);
      line(p, n2);
      frame_valid[p] = 1'b0;
      repeat (6) @(negedge core_clk);
   endtask
   // error event kind k held two cycles
   task pkt_err(input int p, input int k);
      {evt_length_err[p], evt_crc_err[p], evt_header_multibit_fault_flag[p], evt_header_singlebit_fault_flag[p]} = 4'h1 << k;
      repeat (2) @(negedge core_clk);
      {evt_length_err[p], evt_crc_err[p], evt_header_multibit_fault_flag[p], evt_header_singlebit_fault_flag[p]} = 4'h0;
   endtask
   task fmeas(input int p, input logic [7:0] m);
      freq_mhz[p*8 +: 8] = m;
      freq_vld[p] = 1'b1;
      @(negedge core_clk);
      freq_vld[p] = 1'b0;
   endtask
endmodule // rpm_far_model

// File: bench/rpm_port_bank_test.sv
// Purpose: self-checking bench for the receive-port monitor register bank
// Assumes: inputs driven on the falling edge; stability counts shortened
// Notes: port 0 carries most scenarios
`timescale 1ns/1ps
module rpm_port_bank_test;
   logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, reg_rvalid;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [3:0] port_sel = 4'h1, irq_en = 4'h0, zero_st = 4'h0, pass = 4'h0;
   logic [3:0] lv, fv, el, ec, e2, e1, fvld, missing, stable;
   logic [31:0] fmhz;
   int err_total = 0, compares = 0;
   always #2 core_clk = ~core_clk;
   rpm_port_bank #(.STAB_C0(20), .STAB_C1(40), .STAB_C2(80), .STAB_C3(160)) u_rpm_port_bank (
      .core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .port_sel(port_sel), .line_length_change_irq_enable(irq_en),
      .zero_stats_when_unqualified(zero_st), .pass_flag(pass), .line_valid(lv),
      .frame_valid(fv), .evt_length_err(el), .evt_crc_err(ec), .evt_header_multibit_fault_flag(e2),
      .evt_header_singlebit_fault_flag(e1), .freq_vld(fvld), .freq_mhz(fmhz), .link_clock_missing(missing),
      .freq_stable(stable));
   rpm_far_model u_rpm_far_model (.core_clk(core_clk), .line_valid(lv), .frame_valid(fv),
      .evt_length_err(el), .evt_crc_err(ec), .evt_header_multibit_fault_flag(e2), .evt_header_singlebit_fault_flag(e1),
      .freq_vld(fvld), .freq_mhz(fmhz));
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge core_clk) reg_wr = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(negedge core_clk) {reg_rd, reg_addr} = {1'b1, a};
      @(negedge core_clk) reg_rd = 1'b0;
      chk("rvalid", 8'h01, {7'h00, reg_rvalid});
      chk(n, e, reg_rdata);
   endtask
   task t_reset;
      chk("missing", 8'h0F, {4'h0, missing});
      rd(8'h77, 8'hC5, "freq_ctl");
      rd(8'h78, 8'h00, "mbox_a");
      rd(8'h79, 8'h01, "mbox_b");
      rd(8'h7A, 8'h00, "sts");
   endtask
   task t_ports;
      port_sel = 4'h2;
      wr(8'h78, 8'hA5);
      rd(8'h78, 8'hA5, "mbox_p1");
      wr(8'h7A, 8'hFF);
      wr(8'h75, 8'h3C);
      rd(8'h7A, 8'h00, "sts_wr");
      rd(8'h75, 8'h00, "len_wr");
      rd(8'h50, 8'h00, "unmapped");
      port_sel = 4'h1;
      rd(8'h78, 8'h00, "mbox_p0");
   endtask
   task t_len;
      u_rpm_far_model.frame(0, 416, 291);
      rd(8'h75, 8'h01, "len_hi");
      u_rpm_far_model.frame(0, 100, 767);
      rd(8'h76, 8'h23, "len_lo_snap");
      rd(8'h75, 8'h02, "len_hi2");
      rd(8'h76, 8'hFF, "len_lo2");
      irq_en = 4'h1;
      u_rpm_far_model.frame(0, 20, 336);
      u_rpm_far_model.frame(0, 20, 352);
      rd(8'h75, 8'h01, "frz_hi");
      rd(8'h76, 8'h50, "frz_lo");
      u_rpm_far_model.frame(0, 20, 369);
      rd(8'h75, 8'h01, "unfrz_hi");
      rd(8'h76, 8'h71, "unfrz_lo");
      zero_st = 4'h1;
      rd(8'h75, 8'h00, "len_nopass");
      pass = 4'h1;
      rd(8'h75, 8'h01, "len_pass");
   endtask
   task t_err;
      int k;
      for (k = 0; k < 4; k++) begin
         u_rpm_far_model.pkt_err(0, k);
         repeat (3) @(negedge core_clk);
         rd(8'h7A, 8'h01 << k, "sts_set");
         rd(8'h7A, 8'h00, "sts_clr");
      end
   endtask
   task t_freq;
      wr(8'h77, 8'h45);
      u_rpm_far_model.fmeas(0, 8'd50);
      @(negedge core_clk);
      chk("ok_clk", 8'h00, {7'h00, missing[0]});
      u_rpm_far_model.fmeas(0, 8'd4);
      @(negedge core_clk);
      chk("low_clk", 8'h01, {7'h00, missing[0]});
      u_rpm_far_model.fmeas(0, 8'd50);
      @(negedge core_clk);
      chk("ok_clk2", 8'h00, {7'h00, missing[0]});
      repeat (8) @(negedge core_clk);
      chk("unstable", 8'h00, {7'h00, stable[0]});
      repeat (20) @(negedge core_clk);
      chk("stable", 8'h01, {7'h00, stable[0]});
      u_rpm_far_model.fmeas(0, 8'd51);
      repeat (3) @(negedge core_clk);
      chk("in_band", 8'h01, {7'h00, stable[0]});
      u_rpm_far_model.fmeas(0, 8'd53);
      repeat (3) @(negedge core_clk);
      chk("out_band", 8'h00, {7'h00, stable[0]});
   endtask
   task print_verdict;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      print_verdict;
   end
   initial begin
      repeat (6) @(negedge core_clk);
      resetn = 1'b1;
      t_reset;
      t_ports;
      t_len;
      t_err;
      t_freq;
      print_verdict;
   end
endmodule // rpm_port_bank_test
